// >>> hw/ebra_ctrl.sv
// external bus cycle sequencer with ready handling and hold arbitration
// assumes ready and hold are already synchronous to sys_clk
module ebra_ctrl (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic access_req,
   input wire logic access_write,
   input wire logic [15:0] access_addr,
   input wire logic [15:0] access_wdata,
   input wire logic [ebra_pkg::MCW_W-1:0] memory_cycle_wait_count,
   input wire logic rw_delay_en,
   input wire logic multiplexed_bus_wait,
   input wire logic tristate_wait_select,
   input wire logic ready_n,
   input wire logic hold_n,
   input wire logic [15:0] bus_data_in,
   output logic access_done,
   output logic [15:0] access_rdata,
   output logic [15:0] bus_addr,
   output logic [15:0] bus_data_out,
   output logic bus_data_oe,
   output logic bus_ctrl_oe,
   output logic rd_n,
   output logic wr_n,
   output logic ale,
   output logic bus_grant_ack,
   output logic bus_regain_request_n,
   output logic system_clock_out
);
   import ebra_pkg::*;

   ebra_state_e st_q;
   ebra_state_e st_d;
   logic wait_zero;
   logic gap_zero;
   logic wait_load;
   logic gap_load;
   logic [MCW_W-1:0] wait_val;
   logic [1:0] gap_val;
   logic [1:0] gap_cnt;
   logic write_q;
   logic strobe_on;
   logic hold_req;
   logic cycle_end;
   logic hold_rise;
   logic hold_q;

   // programmed waits and gap length counters
   ebra_down_counter #(.W(MCW_W)) u_wait (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(wait_load),
      .value(wait_val),
      .zero(wait_zero)
   );
   ebra_down_counter #(.W(2)) u_gap (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(gap_load),
      .value(gap_cnt),
      .zero(gap_zero)
   );

   assign gap_val = !multiplexed_bus_wait ? GAP_DEMUX :
      (tristate_wait_select ? GAP_MUX_TRI : GAP_MUX);
   // gap state lasts gap_val cycles, so the count loads one less
   assign gap_cnt = (gap_val == GAP_DEMUX) ? GAP_DEMUX : gap_val - 2'h1;
   // programmed waits; the delay state adds its own cycle
   assign wait_val = memory_cycle_wait_count;
   assign hold_req = !hold_n;
   assign hold_rise = hold_n && !hold_q;
   // ready low at sampling point ends the cycle
   assign cycle_end = (st_q == EBRA_RDY) && !ready_n;
   // reload after the delay state so no wait is lost
   assign wait_load = (st_q == EBRA_ADDR) || (st_q == EBRA_DLY);
   assign gap_load = cycle_end;
   assign strobe_on = (st_q == EBRA_WAIT) || (st_q == EBRA_RDY);

   // next state of the cycle sequencer
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         EBRA_IDLE:
         begin
            if (hold_req)
               st_d = EBRA_HOLD;
            else if (access_req)
               st_d = EBRA_ADDR;
         end
         EBRA_ADDR:
         begin
            st_d = rw_delay_en ? EBRA_DLY : EBRA_WAIT;
         end
         EBRA_DLY:
         begin
            st_d = EBRA_WAIT;
         end
         EBRA_WAIT:
         begin
            // programmed waits run before ready is looked at
            if (wait_zero)
               st_d = EBRA_RDY;
         end
         EBRA_RDY:
         begin
            // ready high inserts a wait state
            if (!ready_n)
               st_d = (gap_val == GAP_DEMUX) ? EBRA_IDLE : EBRA_GAP;
         end
         EBRA_GAP:
         begin
            if (gap_zero)
               st_d = EBRA_IDLE;
         end
         EBRA_HOLD:
         begin
            // regain only on hold going high
            if (hold_rise)
               st_d = EBRA_IDLE;
         end
         default:
         begin
            st_d = EBRA_IDLE;
         end
      endcase
   end

   // sequencer and latched transfer info
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= EBRA_IDLE;
         write_q <= 1'b0;
         hold_q <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
         hold_q <= hold_n;
         if (st_q == EBRA_IDLE)
            write_q <= access_write;
      end
   end

   // pin registers; all outputs come from flops
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_addr <= 16'h0000;
         bus_data_out <= 16'h0000;
         bus_data_oe <= 1'b0;
         bus_ctrl_oe <= 1'b1;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         ale <= 1'b0;
         bus_grant_ack <= 1'b0;
         bus_regain_request_n <= 1'b1;
         access_done <= 1'b0;
         access_rdata <= 16'h0000;
         system_clock_out <= 1'b0;
      end
      else
      begin
         system_clock_out <= ~system_clock_out;
         if (st_d == EBRA_ADDR)
         begin
            bus_addr <= access_addr;
            bus_data_out <= access_wdata;
         end
         ale <= (st_d == EBRA_ADDR);
         // strobe asserts after the optional delay state
         rd_n <= !(((st_d == EBRA_WAIT) || (st_d == EBRA_RDY))
            && !write_q);
         wr_n <= !(((st_d == EBRA_WAIT) || (st_d == EBRA_RDY))
            && write_q);
         bus_data_oe <= write_q && (st_d == EBRA_WAIT ||
            st_d == EBRA_RDY || st_d == EBRA_DLY);
         bus_grant_ack <= (st_d == EBRA_HOLD);
         bus_ctrl_oe <= (st_d != EBRA_HOLD);
         // request bus back only with pending access
         bus_regain_request_n <= !((st_d == EBRA_HOLD) && access_req);
         access_done <= cycle_end;
         if (cycle_end && !write_q)
            access_rdata <= bus_data_in;
      end
   end

   // ready high at sampling holds the strobe
   a_ready_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_q == EBRA_RDY && ready_n) |=> (st_q == EBRA_RDY))
      else $error("ready high did not insert wait");
   // ready low ends cycle with done pulse
   a_ready_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_q == EBRA_RDY && !ready_n) |=> access_done ##1 !access_done)
      else $error("cycle not terminated by ready");
   a_wait_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_q == EBRA_WAIT && !wait_zero) |=> (st_q != EBRA_RDY))
      else $error("ready sampled before programmed waits");
   // delay postpones the strobe one cycle
   a_rw_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_q == EBRA_ADDR && rw_delay_en) |=> rd_n && wr_n)
      else $error("strobe not delayed");
   // muxed with tri-state gives a two cycle gap
   a_gap_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cycle_end && gap_val == GAP_MUX_TRI) |=>
      (st_q == EBRA_GAP) [*2] ##1 (st_q == EBRA_IDLE))
      else $error("tri-state gap not two cycles");
   a_gap_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cycle_end && gap_val == GAP_DEMUX) |=> (st_q == EBRA_IDLE))
      else $error("demux gap not zero");
   // no grant during a running cycle
   a_hold_after: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(bus_grant_ack) |-> $past(st_q) == EBRA_IDLE)
      else $error("hold granted mid cycle");
   a_hold_stay: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_q == EBRA_HOLD && !hold_rise) |=> (st_q == EBRA_HOLD))
      else $error("bus regained without hold release");
   a_hold_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
      bus_grant_ack |-> !bus_ctrl_oe && !bus_data_oe && !ale)
      else $error("bus driven while granted away");
   a_bus_regain_request_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !bus_regain_request_n |-> bus_grant_ack)
      else $error("regain request outside hold");
endmodule : ebra_ctrl

// >>> hw/ebra_pkg.sv
// constants for the external bus ready and arbitration controller
// assumes a single 100 MHz system clock and no register bus
package ebra_pkg;
   // clock period in ns (100 MHz rate)
   localparam int CLK_PERIOD_NS = 10;
   // width of the memory cycle wait count field
   localparam int MCW_W = 4;
   localparam logic [MCW_W-1:0] MCW_RESET = 4'h0;
   // demultiplexed bus, no tri-state wait: zero gap
   localparam logic [1:0] GAP_DEMUX = 2'h0;
   // multiplexing wait state alone
   localparam logic [1:0] GAP_MUX = 2'h1;
   // multiplexed bus with tri-state wait: two clock cycles
   localparam logic [1:0] GAP_MUX_TRI = 2'h2;
   // read/write delay: strobe leading edge one cycle late
   localparam logic [1:0] RWD_CYCLES = 2'h1;

   // bus cycle sequencer states
   typedef enum logic [2:0]
   {
      EBRA_IDLE = 3'b000,
      EBRA_ADDR = 3'b001,
      EBRA_DLY  = 3'b010,
      EBRA_WAIT = 3'b011,
      EBRA_RDY  = 3'b100,
      EBRA_GAP  = 3'b101,
      EBRA_HOLD = 3'b110
   } ebra_state_e;
endpackage : ebra_pkg

// >>> hw/ebra_down_counter.sv
// small loadable down counter used for programmed wait and gap counts
// assumes synchronous load, counts down to zero and stops
module ebra_down_counter #(
   parameter int W = 4
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic zero
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // next count: load wins, else count to zero
   assign cnt_d = load ? value :
      ((cnt_q != '0) ? cnt_q - W'(1) : cnt_q);
   assign zero = (cnt_q == '0);

   // count register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end
endmodule : ebra_down_counter

// >>> verif/ebra_far_model.sv
// far side: memory answering strobes with ready_n and read data
// assumes strobes are registered on sys_clk rising edges
module ebra_far_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [15:0] bus_addr,
   input wire logic [15:0] bus_data_out,
   input wire logic [3:0] ready_wait,
   output logic ready_n,
   output logic [15:0] bus_data_in,
   output logic [15:0] last_write
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   logic [15:0] junk_q;
   wire logic strobe = !rd_n || !wr_n;
   // released data lines move every cycle, never stale
   assign bus_data_in = !rd_n ? ~bus_addr : junk_q;
   // prompt or slow ready, withdrawn after strobe
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 4'h0;
         ready_n <= 1'b1;
         junk_q <= 16'h0;
         last_write <= 16'h0;
      end
      else
      begin
         junk_q <= junk_q + 16'h1357;
         cnt_q <= strobe ? cnt_q + 4'h1 : 4'h0;
         ready_n <= !(strobe && cnt_q >= ready_wait);
         if (!wr_n)
            last_write <= bus_data_out;
      end
   end
endmodule : ebra_far_model

// >>> verif/tb_ebra_ctrl.sv
// bench: timed accesses, gaps and hold handover
// assumes the far model answers every strobe
`define CHK(nm, e, v) \
   begin num_checks++; if ((v) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, v); end end
module tb_ebra_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_n = 0, access_req = 0, access_write = 0;
   logic [15:0] access_addr = 16'h1234, access_wdata = 16'hA5C3;
   logic [3:0] memory_cycle_wait_count = 4'h0, ready_wait = 4'h0;
   logic rw_delay_en = 0, multiplexed_bus_wait = 0;
   logic tristate_wait_select = 0, hold_n = 1;
   logic ready_n, access_done, bus_data_oe, bus_ctrl_oe, rd_n, wr_n;
   logic ale, bus_grant_ack, bus_regain_request_n, system_clock_out;
   logic [15:0] bus_data_in, access_rdata, bus_addr, bus_data_out;
   logic [15:0] last_write;
   logic ck;
   int num_errors = 0, num_checks = 0, l0, l1, n, q;
   int g[3];
   always #5 sys_clk = ~sys_clk;
   ebra_ctrl dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .access_req(access_req),
      .access_write(access_write), .access_addr(access_addr),
      .access_wdata(access_wdata),
      .memory_cycle_wait_count(memory_cycle_wait_count),
      .rw_delay_en(rw_delay_en),
      .multiplexed_bus_wait(multiplexed_bus_wait),
      .tristate_wait_select(tristate_wait_select),
      .ready_n(ready_n), .hold_n(hold_n), .bus_data_in(bus_data_in),
      .access_done(access_done), .access_rdata(access_rdata),
      .bus_addr(bus_addr), .bus_data_out(bus_data_out),
      .bus_data_oe(bus_data_oe), .bus_ctrl_oe(bus_ctrl_oe),
      .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
      .bus_grant_ack(bus_grant_ack),
      .bus_regain_request_n(bus_regain_request_n),
      .system_clock_out(system_clock_out)
   );
   ebra_far_model far_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .rd_n(rd_n), .wr_n(wr_n),
      .bus_addr(bus_addr), .bus_data_out(bus_data_out),
      .ready_wait(ready_wait), .ready_n(ready_n),
      .bus_data_in(bus_data_in), .last_write(last_write)
   );
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // bounded wait on a flag seen at falling edges
   task automatic wait_on(ref logic s, input logic v, output int c);
      for (c = 0; c < 300 && s !== v; c++)
         @(negedge sys_clk);
      if (c == 300)
      begin
         num_errors++;
         end_sim();
      end
   endtask : wait_on
   task automatic cfg(logic [3:0] m, logic d, x, t, logic [3:0] r);
      @(posedge sys_clk);
      memory_cycle_wait_count <= m;
      rw_delay_en <= d;
      multiplexed_bus_wait <= x;
      tristate_wait_select <= t;
      ready_wait <= r;
   endtask : cfg
   // one access; a retake at the drop edge is let run out
   task automatic acc(logic w, logic keep, output int lat);
      @(posedge sys_clk);
      access_write <= w;
      access_req <= 1'b1;
      @(negedge sys_clk);
      wait_on(access_done, 1'b1, lat);
      `CHK("rd_n_end", 1'b1, rd_n)
      if (!w)
         `CHK("rdata", ~access_addr, access_rdata)
      if (!keep)
      begin
         @(posedge sys_clk);
         access_req <= 1'b0;
         q = 0;
         for (n = 0; n < 300 && q < 4; n++)
         begin
            @(negedge sys_clk);
            q = (rd_n & wr_n & !ale) ? q + 1 : 0;
         end
         if (q < 4)
         begin
            num_errors++;
            end_sim();
         end
      end
   endtask : acc
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      acc(0, 0, l0);
      cfg(4'h3, 0, 0, 0, 4'h0);
      acc(0, 0, l1);
      `CHK("mcw_lat", l0 + 3, l1)
      cfg(4'h0, 0, 0, 0, 4'h2);
      acc(0, 0, l1);
      `CHK("rdy_lat", l0 + 2, l1)
      cfg(4'h2, 1, 0, 0, 4'h0);
      acc(0, 0, l1);
      `CHK("rwd_lat", l0 + 3, l1)
      cfg(4'h0, 0, 0, 0, 4'h0);
      acc(1, 0, l1);
      `CHK("wdata", access_wdata, last_write)
      // gap from done to next address phase, per bus mode
      for (int k = 0; k < 3; k++)
      begin
         cfg(4'h0, 0, k > 0, k == 2, 4'h0);
         acc(0, 1, l1);
         wait_on(ale, 1'b1, g[k]);
         acc(0, 0, l1);
      end
      `CHK("gap_mux", g[0] + 1, g[1])
      `CHK("gap_tri", g[0] + 2, g[2])
      cfg(4'h0, 0, 0, 0, 4'h0);
      hold_n <= 1'b0;
      wait_on(bus_grant_ack, 1'b1, n);
      `CHK("ctrl_off", 1'b0, bus_ctrl_oe)
      `CHK("data_off", 1'b0, bus_data_oe)
      `CHK("no_req", 1'b1, bus_regain_request_n)
      @(posedge sys_clk);
      access_req <= 1'b1;
      repeat (4) @(negedge sys_clk);
      `CHK("quiet", 1'b1, rd_n & !ale)
      `CHK("req", 1'b0, bus_regain_request_n)
      `CHK("kept", 1'b1, bus_grant_ack)
      ck = system_clock_out;
      @(negedge sys_clk);
      `CHK("clk_out", ~ck, system_clock_out)
      @(posedge sys_clk);
      hold_n <= 1'b1;
      acc(0, 0, l1);
      `CHK("back", 1'b0, bus_grant_ack)
      @(posedge sys_clk);
      hold_n <= 1'b0;
      wait_on(bus_grant_ack, 1'b1, n);
      @(posedge sys_clk);
      hold_n <= 1'b1;
      wait_on(bus_grant_ack, 1'b0, n);
      `CHK("no_req2", 1'b1, bus_regain_request_n)
      cfg(4'h0, 0, 0, 0, 4'h4);
      access_req <= 1'b1;
      repeat (3) @(posedge sys_clk);
      hold_n <= 1'b0;
      wait_on(access_done, 1'b1, n);
      `CHK("late_grant", 1'b0, bus_grant_ack)
      @(posedge sys_clk);
      access_req <= 1'b0;
      wait_on(bus_grant_ack, 1'b1, n);
      `CHK("handed", 1'b0, bus_ctrl_oe)
      end_sim();
   end
endmodule : tb_ebra_ctrl
